// *** design/hirqts_consts.svh ***
// Constants for the host interrupt status and timestamp block
`ifndef HIRQTS_CONSTS_SVH
`define HIRQTS_CONSTS_SVH
`define HIRQTS_TS_W          40
`define HIRQTS_TS_BYTES      5
`define HIRQTS_BYTE_W        8
`define HIRQTS_ADDR_W        8
`define HIRQTS_OFS_TS0       8'h26
`define HIRQTS_OFS_TS4       8'h2A
`define HIRQTS_OFS_ID        8'h2B
`define HIRQTS_OFS_STATUS    8'h2D
`define HIRQTS_BIT_ASSERTED  0
`define HIRQTS_WAKE_LSB      1
`define HIRQTS_NWAKE_LSB     3
`define HIRQTS_DBG_BIT       5
`define HIRQTS_CH_WAKE       0
`define HIRQTS_CH_NWAKE      1
`define HIRQTS_CH_DBG        2
`define HIRQTS_ZERO8         8'h00
`define HIRQTS_ZERO2         2'h0
`define HIRQTS_ZERO40        40'h00_0000_0000
`endif

// *** design/hirqts_pkg.sv ***
// Types shared by the host interrupt status and timestamp block
package hirqts_pkg;
    // Reason code of a FIFO channel
    typedef enum logic [1:0] {
        HIRQTS_COND_NONE      = 2'b00,
        HIRQTS_COND_IMMEDIATE = 2'b01,
        HIRQTS_COND_LATENCY   = 2'b10,
        HIRQTS_COND_WATERMARK = 2'b11
    } hirqts_cond_t;
    // Sequencer state of an interrupt raise
    typedef enum logic [1:0] {
        HIRQTS_IDLE    = 2'b00,
        HIRQTS_STAMP   = 2'b01,
        HIRQTS_STATUS  = 2'b10,
        HIRQTS_ASSERT  = 2'b11
    } hirqts_state_t;
endpackage

// *** design/hirqts_chan.sv ***
// One pending-source channel: holds its condition until the host reads it
`timescale 1ns/1ps
`default_nettype none
`include "hirqts_consts.svh"
module hirqts_chan
    import hirqts_pkg::*;
(
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rstn,
    // Event side
    input  wire logic         load,
    input  wire hirqts_cond_t cond,
    input  wire logic         drained,
    // Result
    output var  hirqts_cond_t held
);
    // Latch on a load with a reason; a drain clears unless such a load arrives the same cycle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            held <= HIRQTS_COND_NONE;
        end else if (load && cond != HIRQTS_COND_NONE) begin
            held <= cond;
        end else if (drained) begin
            held <= HIRQTS_COND_NONE;
        end
    end
endmodule
`default_nettype wire

// *** design/hirqts_top.sv ***
// Host interrupt status, event timestamp and identifier registers
`timescale 1ns/1ps
`default_nettype none
`include "hirqts_consts.svh"
////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Store a 40-bit timestamp of the interrupt line only; event-request select keeps the last one.
// - With select clear, capture the time the event request is taken, three cycles before the line asserts.
// - Timestamp updates first, then status, then the interrupt line.
// - With select set, timestamp registers keep the last line stamp.
// - A read-only register returns a fixed identification code.
// - Status register shows pending data for all three channels.
// - Masks gate only the asserted bit and line, not pending bits.
// - Reading a channel clears only that channel's status bits.
// - Asserted bit and line stay active until every unmasked source drained.
// - Status bit 0 mirrors the interrupt line level.
// - Bits 1-2 hold wake-up FIFO reason: none, immediate, latency, watermark.
// - Timestamp registers are reachable in the same burst as status.
// - Bits 3-4 hold non-wake-up FIFO reason with the same codes.
// - Bit 5 set when status channel holds synchronous command data.
module hirqts_top
    import hirqts_pkg::*;
#(
    parameter logic [7:0] PART_ID = 8'h5A    // Arbitrary identification value
)(
    // Clock and reset
    input  wire logic                       clk,
    input  wire logic                       rstn,
    // Free running time base
    input  wire logic [`HIRQTS_TS_W-1:0]    time_now,
    // Source events from the FIFO and status logic
    input  wire logic                       ev_valid,
    input  wire hirqts_cond_t               ev_wake,
    input  wire hirqts_cond_t               ev_nwake,
    input  wire logic                       ev_dbg,
    // Host control settings
    input  wire logic                       ts_event_sel,
    input  wire logic                       mask_wake,
    input  wire logic                       mask_nwake,
    // Channel drain strobes from host reads of each channel
    input  wire logic                       rd_wake,
    input  wire logic                       rd_nwake,
    input  wire logic                       rd_dbg,
    // Register read port
    input  wire logic                       reg_rd,
    input  wire logic [`HIRQTS_ADDR_W-1:0]  reg_addr,
    output logic      [7:0]                 reg_rdata,
    // Interrupt line to the host
    output logic                            host_irq_line
);
    hirqts_state_t         state;
    hirqts_state_t         next_state;
    hirqts_cond_t          wake_held;
    hirqts_cond_t          nwake_held;
    hirqts_cond_t          wake_cond;
    hirqts_cond_t          nwake_cond;
    logic                  dbg_held;
    logic                  dbg_cond;
    logic                  load;
    logic [`HIRQTS_TS_W-1:0] stamp;
    logic [`HIRQTS_TS_W-1:0] ev_time;
    logic [`HIRQTS_TS_W-1:0] rd_shadow;
    logic                  any_pending;
    logic                  any_unmasked;
    logic [7:0]            status_val;
    logic                  hit_ts0;
    logic                  hit_ts_hi;
    logic                  hit_id;
    logic                  hit_status;
    logic [2:0]            ts_byte_sel;
    logic [7:0]            shadow_byte;

    ////////////////////////////////////////////////////////////////////////////
    // Raise sequencer: stamp, then status, then line
    // Busy three cycles after a take; requests in that time are dropped
    always_comb begin
        next_state = state;
        unique case (state)
            HIRQTS_IDLE:   if (ev_valid) next_state = HIRQTS_STAMP;
            HIRQTS_STAMP:  next_state = HIRQTS_STATUS;
            HIRQTS_STATUS: next_state = HIRQTS_ASSERT;
            HIRQTS_ASSERT: next_state = HIRQTS_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= HIRQTS_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Event content and time held from request until status load
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wake_cond  <= HIRQTS_COND_NONE;
            nwake_cond <= HIRQTS_COND_NONE;
            dbg_cond   <= 1'b0;
            ev_time    <= `HIRQTS_ZERO40;
        end else if (state == HIRQTS_IDLE && ev_valid) begin
            wake_cond  <= ev_wake;
            nwake_cond <= ev_nwake;
            dbg_cond   <= ev_dbg;
            ev_time    <= time_now;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Timestamp capture, only when the line is the selected event
    // With event-request stamping selected the last line stamp is kept
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stamp <= `HIRQTS_ZERO40;
        end else if (state == HIRQTS_STAMP && !ts_event_sel) begin
            stamp <= ev_time;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pending channels
    assign load = (state == HIRQTS_STATUS);

    // Wake-up FIFO reason
    hirqts_chan u_wake (
        .clk     (clk),
        .rstn    (rstn),
        .load    (load),
        .cond    (wake_cond),
        .drained (rd_wake),
        .held    (wake_held)
    );

    // Non-wake-up FIFO reason
    hirqts_chan u_nwake (
        .clk     (clk),
        .rstn    (rstn),
        .load    (load),
        .cond    (nwake_cond),
        .drained (rd_nwake),
        .held    (nwake_held)
    );

    // Status channel bit, loaded with the FIFO channels so it never leads the stamp
    // A new event beats a drain in the same cycle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dbg_held <= 1'b0;
        end else if (load && dbg_cond) begin
            dbg_held <= 1'b1;
        end else if (rd_dbg) begin
            dbg_held <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Line level: masks gate only the line
    assign any_pending  = (wake_held != HIRQTS_COND_NONE) ||
                          (nwake_held != HIRQTS_COND_NONE) || dbg_held;
    assign any_unmasked = ((wake_held != HIRQTS_COND_NONE) && !mask_wake) ||
                          ((nwake_held != HIRQTS_COND_NONE) && !mask_nwake) ||
                          dbg_held;

    // Line register; a mask set while high drops the line if no unmasked source is left, and clearing the
    // mask again does not raise it before the next event sequence
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            host_irq_line <= 1'b0;
        end else if (state == HIRQTS_ASSERT) begin
            host_irq_line <= any_unmasked;
        end else if (!any_pending) begin
            host_irq_line <= 1'b0;
        end else if (!any_unmasked) begin
            host_irq_line <= 1'b0;
        end
    end

    // Status byte image
    // Bits 6 and 7 stay zero, bit 0 follows the registered line
    always_comb begin
        status_val = `HIRQTS_ZERO8;
        status_val[`HIRQTS_BIT_ASSERTED] = host_irq_line;
        status_val[`HIRQTS_WAKE_LSB +: 2] = wake_held;
        status_val[`HIRQTS_NWAKE_LSB +: 2] = nwake_held;
        status_val[`HIRQTS_DBG_BIT] = dbg_held;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read address decode and byte select of the upper stamp bytes
    assign hit_ts0     = (reg_addr == `HIRQTS_OFS_TS0);
    assign hit_ts_hi   = (reg_addr > `HIRQTS_OFS_TS0) && (reg_addr <= `HIRQTS_OFS_TS4);
    assign hit_id      = (reg_addr == `HIRQTS_OFS_ID);
    assign hit_status  = (reg_addr == `HIRQTS_OFS_STATUS);
    assign ts_byte_sel = 3'(reg_addr - `HIRQTS_OFS_TS0);
    assign shadow_byte = rd_shadow[`HIRQTS_BYTE_W * ts_byte_sel +: `HIRQTS_BYTE_W];

    // Shadow of the stamp taken on a status or stamp byte 0 read, so a burst sees one value
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rd_shadow <= `HIRQTS_ZERO40;
        end else if (reg_rd && (hit_status || hit_ts0)) begin
            rd_shadow <= stamp;
        end
    end

    // Registered read data; unmapped offsets read zero
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= `HIRQTS_ZERO8;
        end else if (reg_rd) begin
            if (hit_ts0) begin
                reg_rdata <= stamp[`HIRQTS_BYTE_W-1:0];
            end else if (hit_ts_hi) begin
                reg_rdata <= shadow_byte;
            end else if (hit_id) begin
                reg_rdata <= PART_ID;
            end else if (hit_status) begin
                reg_rdata <= status_val;
            end else begin
                reg_rdata <= `HIRQTS_ZERO8;
            end
        end
    end
endmodule
`default_nettype wire

// *** testbench/hirqts_chk_sva.sv ***
// Checker for the host interrupt status and timestamp block
`timescale 1ns/1ps
`default_nettype none
module hirqts_chk
    import hirqts_pkg::*;
#(
    parameter logic [7:0] PART_ID = 8'h5A    // Arbitrary identification value
)(
    // Clock, reset and events
    input wire logic         clk,
    input wire logic         rstn,
    input wire logic         ev_valid,
    input wire hirqts_cond_t ev_wake,
    // Masks and drains
    input wire logic         mask_wake,
    input wire logic         mask_nwake,
    input wire logic         rd_wake,
    input wire logic         rd_nwake,
    input wire logic         rd_dbg,
    // Register port and line
    input wire logic         reg_rd,
    input wire logic         host_irq_line,
    input wire logic [7:0]   reg_addr,
    input wire logic [7:0]   reg_rdata
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////////////////////
    // Register read results
    property p_id; reg_rd && reg_addr == 8'h2B |=> reg_rdata == PART_ID; endproperty
    a_id: assert property (p_id) else $error("identifier read wrong");
    property p_hi; reg_rd && reg_addr == 8'h2D |=> reg_rdata[7:6] == 2'h0; endproperty
    a_hi: assert property (p_hi) else $error("status top bits set");
    property p_unm; reg_rd && reg_addr == 8'h2C |=> reg_rdata == 8'h00; endproperty
    a_unm: assert property (p_unm) else $error("hole in map not zero");
    property p_hold; !reg_rd |=> $stable(reg_rdata); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_bit0; reg_rd && reg_addr == 8'h2D |=>
        reg_rdata[0] == $past(host_irq_line);
    endproperty
    a_bit0: assert property (p_bit0) else $error("status bit 0 not line");
    ////////////////////////////////////////////////////////////////////////////
    // Interrupt line sequencing
    property p_evt; ev_valid && ev_wake != HIRQTS_COND_NONE && !mask_wake && !host_irq_line
        && !$past(ev_valid) && !$past(ev_valid, 2) && !$past(ev_valid, 3)
        |-> ##1 !host_irq_line ##1 !host_irq_line ##1 !host_irq_line ##1 host_irq_line;
    endproperty
    a_evt: assert property (p_evt) else $error("line not raised fourth edge");
    property p_rise; $rose(host_irq_line) |-> $past(ev_valid, 4);
    endproperty
    a_rise: assert property (p_rise) else $error("line rose without cause");
    property p_keep; $fell(host_irq_line) |-> $past(rd_wake | rd_nwake | rd_dbg)
        || $past(rd_wake | rd_nwake | rd_dbg, 2) || $past(mask_wake | mask_nwake)
        || $past(mask_wake | mask_nwake, 2);
    endproperty
    a_keep: assert property (p_keep) else $error("line fell without drain");
    c_line: cover property ($rose(host_irq_line));
    c_drain: cover property ($fell(host_irq_line));
    c_mask: cover property (ev_valid && mask_wake);
endmodule
bind hirqts_top hirqts_chk #(.PART_ID(PART_ID)) chk_u (.clk, .rstn, .ev_valid, .ev_wake,
    .mask_wake, .mask_nwake, .rd_wake, .rd_nwake, .rd_dbg, .reg_rd, .host_irq_line,
    .reg_addr, .reg_rdata);
`default_nettype wire

// *** testbench/hirqts_host.sv ***
// Host model: register reads and channel drains
`timescale 1ns/1ps
`default_nettype none
module hirqts_host (
    // Clock and read data
    input  wire logic       clk,
    input  wire logic [7:0] reg_rdata,
    // Register requests
    output var  logic       reg_rd,
    output var  logic [7:0] reg_addr,
    // Channel drain strobes
    output var  logic       rd_wake,
    output var  logic       rd_nwake,
    output var  logic       rd_dbg
);
    initial begin
        {reg_rd, rd_wake, rd_nwake, rd_dbg, reg_addr} = 12'h000;
    end
    // One read, data taken one edge after the request edge
    task automatic read(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // One-cycle drain pulse per channel in mask m
    task automatic drain(input logic [2:0] m);
        @(posedge clk);
        {rd_dbg, rd_nwake, rd_wake} <= m;
        @(posedge clk);
        {rd_dbg, rd_nwake, rd_wake} <= 3'h0;
    endtask
    // Any set status bit means work waits
    function automatic logic pending(input logic [7:0] s);
        return |s;
    endfunction
endmodule
`default_nettype wire

// *** testbench/tb.sv ***
// Testbench for the host interrupt status and timestamp block
`timescale 1ns/1ps
`default_nettype none
module tb;
    import hirqts_pkg::*;
    logic clk = 0, rstn = 0, ev_valid = 0, ev_dbg = 0, ts_event_sel = 0, mask_wake = 0;
    logic mask_nwake = 0, reg_rd, rd_wake, rd_nwake, rd_dbg, host_irq_line;
    logic [39:0] time_now = 40'hA5_C3_FF_FF_F0, tk, ts;
    logic [7:0] reg_addr, reg_rdata, d;
    logic [4:0] tab [3] = '{5'b1_10_01, 5'b0_11_10, 5'b1_00_11};
    hirqts_cond_t ev_wake = HIRQTS_COND_NONE, ev_nwake = HIRQTS_COND_NONE;
    int num_errors = 0, cmp_count = 0;
    always #10 clk = ~clk;
    always @(posedge clk) time_now <= time_now + 40'h1;
    hirqts_top #(.PART_ID(8'h5A)) dut_u (.clk, .rstn, .time_now, .ev_valid, .ev_wake,
        .ev_nwake, .ev_dbg, .ts_event_sel, .mask_wake, .mask_nwake, .rd_wake, .rd_nwake,
        .rd_dbg, .reg_rd, .reg_addr, .reg_rdata, .host_irq_line);
    hirqts_host host_u (.clk, .reg_rdata, .reg_rd, .rd_wake, .rd_nwake, .rd_dbg, .reg_addr);
    ////////////////////////////////////////////////////////////////////////////
    // Compare, read and event helpers
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        host_u.read(a, d);
        chk(d, e);
    endtask
    task automatic rdts(input logic [39:0] e);
        host_u.read(8'h2D, d);
        for (int i = 0; i < 5; i++) rdchk(8'h26 + 8'(i), e[8*i+:8]);
    endtask
    task automatic fire(input logic [4:0] c);
        @(posedge clk);
        ev_valid <= 1'b1;
        ev_dbg <= c[4];
        ev_nwake <= hirqts_cond_t'(c[3:2]);
        ev_wake <= hirqts_cond_t'(c[1:0]);
        @(posedge clk);
        tk = time_now;
        ev_valid <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic give_verdict();
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Test sequence
    initial begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        rdchk(8'h2D, 8'h00);
        rdchk(8'h2B, 8'h5A);
        rdchk(8'h2C, 8'h00);
        foreach (tab[i]) begin
            fire(tab[i]);
            ts = tk;
            chk({7'h0, host_irq_line}, 8'h01);
            rdchk(8'h2D, {2'b00, tab[i], 1'b1});
            chk({7'h0, host_u.pending(d)}, 8'h01);
            rdts(ts);
            host_u.drain(3'b001);
            rdchk(8'h2D, {2'b00, tab[i][4:2], 3'b001});
            host_u.drain(3'b110);
            repeat (2) @(posedge clk);
            #1 chk({7'h0, host_irq_line}, 8'h00);
            rdchk(8'h2D, 8'h00);
        end
        @(posedge clk) ts_event_sel <= 1'b1;
        fire(5'b0_00_01);
        chk({7'h0, host_irq_line}, 8'h01);
        rdts(ts);
        host_u.drain(3'b001);
        @(posedge clk) ts_event_sel <= 1'b0;
        mask_wake <= 1'b1;
        mask_nwake <= 1'b1;
        fire(5'b0_01_11);
        chk({7'h0, host_irq_line}, 8'h00);
        rdchk(8'h2D, 8'h0E);
        host_u.drain(3'b011);
        rdchk(8'h2D, 8'h00);
        @(posedge clk) mask_wake <= 1'b0;
        mask_nwake <= 1'b0;
        repeat (3) @(posedge clk);
        give_verdict();
    end
    // Watchdog against a hang
    initial begin
        #100000;
        num_errors++;
        give_verdict();
    end
endmodule
`default_nettype wire
